// File: rtl/rtc_consts.svh
/*
 file: offsets, field positions, counter limits and encodings of the real time clock.
 assumes: included by bare name from the package and the design modules.
*/
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

`define RTC_ADDR_W        5
`define RTC_OFS_CONTROL   5'h00
`define RTC_OFS_CONTROL_X 5'h04
`define RTC_OFS_SRC_SEL   5'h08
`define RTC_OFS_RELOAD    5'h0C
`define RTC_OFS_SECONDS   5'h10
`define RTC_OFS_MINUTES   5'h14
`define RTC_OFS_HOURS     5'h18

`define RTC_BIT_DAY_EN    15
`define RTC_BIT_DAY_FLAG  14
`define RTC_BIT_HOUR_EN   13
`define RTC_BIT_HOUR_FLAG 12
`define RTC_BIT_MIN_EN    11
`define RTC_BIT_MIN_FLAG  10
`define RTC_BIT_SEC_EN    9
`define RTC_BIT_SEC_FLAG  8
`define RTC_BIT_RUN       3
`define RTC_BIT_UPDATE    2
`define RTC_BIT_OE        1
`define RTC_BIT_START     0
`define RTC_BIT_HALF_EN   1
`define RTC_BIT_HALF_FLAG 0
`define RTC_BIT_SRC_LO    8

`define RTC_EV_HALF       0
`define RTC_EV_SEC        1
`define RTC_EV_MIN        2
`define RTC_EV_HOUR       3
`define RTC_EV_DAY        4

`define RTC_SRC_MAIN      2'h0
`define RTC_SRC_SUB       2'h1
`define RTC_SRC_RC        2'h2

`define RTC_SEC_LAST      6'h3B
`define RTC_MIN_LAST      6'h3B
`define RTC_HOUR_LAST     5'h17
`define RTC_DOWN_ZERO     21'h000000

`define RTC_RESP_OKAY     2'h0
`define RTC_RESP_SLVERR   2'h2

`endif

// File: rtl/rtc_pkg.sv
/*
 file: types shared by the real time clock modules.
 assumes: rtc_consts.svh on the include path.
*/
`include "rtc_consts.svh"

package rtc_pkg;

	typedef struct packed {
		logic [`RTC_ADDR_W-1:0] awaddr;
		logic                   awvalid;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic                   wvalid;
		logic                   bready;
		logic [`RTC_ADDR_W-1:0] araddr;
		logic                   arvalid;
		logic                   rready;
	} rtc_axi_req_type;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} rtc_axi_rsp_type;

	typedef struct packed {
		logic [2:0] sync;
		logic       div;
		logic       step;
	} rtc_tick_state_type;

	typedef struct packed {
		logic                   aw_got;
		logic [`RTC_ADDR_W-1:0] aw_addr;
		logic                   w_got;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		rtc_axi_rsp_type        rsp;
		logic [4:0]             flags;
		logic [4:0]             en;
		logic                   oe;
		logic                   start;
		logic                   update;
		logic                   run;
		logic [1:0]             src_sel;
		logic [5:0]             sec_val;
		logic [5:0]             min_val;
		logic [4:0]             hour_val;
		logic [5:0]             sec_cnt;
		logic [5:0]             min_cnt;
		logic [4:0]             hour_cnt;
		logic [20:0]            down_cnt;
		logic                   half;
		logic                   pin_out;
		logic                   pin_oe;
		logic                   irq;
	} rtc_state_type;

endpackage

// File: rtl/rtc_tick.sv
/*
 file: time-count source selection, sampling and divide-by-two step generator.
 assumes: the source clocks are slow against sys_clk (at most a quarter of its rate).
*/
`timescale 1ns/1ps

`include "rtc_consts.svh"

module rtc_tick
	import rtc_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] src_sel,
	input  wire logic       main_osc_clock,
	input  wire logic       sub_osc_clock,
	input  wire logic       internal_rc_clock,
	output logic            step
);

	rtc_tick_state_type t_reg;
	rtc_tick_state_type t_next;
	logic               src_level;

	always_comb begin
		t_next = t_reg;
		unique case (src_sel)
			`RTC_SRC_MAIN: src_level = main_osc_clock;
			`RTC_SRC_SUB:  src_level = sub_osc_clock;
			`RTC_SRC_RC:   src_level = internal_rc_clock;
			default:       src_level = 1'b0; // prohibited code: no clock, time stands
		endcase
		// first stage feeds only the second; edges are seen on stages two and three
		t_next.sync = {t_reg.sync[1:0], src_level};
		t_next.step = 1'b0;
		if (t_reg.sync[1] && !t_reg.sync[2]) begin
			t_next.div  = !t_reg.div;
			t_next.step = t_reg.div;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			t_reg <= '0;
		end else begin
			t_reg <= t_next;
		end
	end

	assign step = t_reg.step;

	// a step needs two source edges, each at least two cycles apart
	chk_step_spacing: assert property (@(posedge sys_clk) disable iff (!rst_n)
		t_reg.step |=> !t_reg.step [*3])
		else $error("step pulses closer than two source periods");

endmodule

// File: rtl/rtc_top.sv
/*
 file: real time clock with AXI4-Lite register slave, down counter, time counters and interval flags.
 assumes: one system clock; source clocks arrive as sampled levels; rst_n is power-on or external
 reset, soft_rst_n any other reset cause, synchronous to sys_clk.
*/
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps

`include "rtc_consts.svh"

module rtc_top
	import rtc_pkg::*;
(
	input  wire logic      sys_clk,
	input  wire logic      rst_n,
	input  wire logic      soft_rst_n,
	input  rtc_axi_req_type axi_req,
	output rtc_axi_rsp_type axi_rsp,
	input  wire logic      main_osc_clock,
	input  wire logic      sub_osc_clock,
	input  wire logic      internal_rc_clock,
	output logic           timer_output_pin,
	output logic           timer_output_pin_oe,
	output logic           irq
);

	rtc_state_type s_reg;
	rtc_state_type s_next;
	logic [20:0]   reload_reg;
	logic [20:0]   reload_next;
	logic          step;
	logic          wr_fire;
	logic          reload_hit;
	logic [4:0]    ev;
	logic [31:0]   wd;
	logic [3:0]    ws;
	logic [31:0]   mw;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic mapped(input logic [`RTC_ADDR_W-1:0] a);
		return a == `RTC_OFS_CONTROL || a == `RTC_OFS_CONTROL_X || a == `RTC_OFS_SRC_SEL ||
			a == `RTC_OFS_RELOAD || a == `RTC_OFS_SECONDS || a == `RTC_OFS_MINUTES || a == `RTC_OFS_HOURS;
	endfunction

	function automatic logic [31:0] read_word(input rtc_state_type s, input logic [20:0] rl,
		input logic [`RTC_ADDR_W-1:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			`RTC_OFS_CONTROL: begin
				r[`RTC_BIT_DAY_EN]    = s.en[`RTC_EV_DAY];
				r[`RTC_BIT_DAY_FLAG]  = s.flags[`RTC_EV_DAY];
				r[`RTC_BIT_HOUR_EN]   = s.en[`RTC_EV_HOUR];
				r[`RTC_BIT_HOUR_FLAG] = s.flags[`RTC_EV_HOUR];
				r[`RTC_BIT_MIN_EN]    = s.en[`RTC_EV_MIN];
				r[`RTC_BIT_MIN_FLAG]  = s.flags[`RTC_EV_MIN];
				r[`RTC_BIT_SEC_EN]    = s.en[`RTC_EV_SEC];
				r[`RTC_BIT_SEC_FLAG]  = s.flags[`RTC_EV_SEC];
				r[`RTC_BIT_RUN]       = s.run;
				r[`RTC_BIT_UPDATE]    = s.update;
				r[`RTC_BIT_OE]        = s.oe;
				r[`RTC_BIT_START]     = s.start;
			end
			`RTC_OFS_CONTROL_X: begin
				r[`RTC_BIT_HALF_EN]   = s.en[`RTC_EV_HALF];
				r[`RTC_BIT_HALF_FLAG] = s.flags[`RTC_EV_HALF];
			end
			`RTC_OFS_SRC_SEL: r[`RTC_BIT_SRC_LO +: 2] = s.src_sel;
			`RTC_OFS_RELOAD:  r[20:0] = rl;
			// time registers read back the running counters
			`RTC_OFS_SECONDS: r[5:0] = s.sec_cnt;
			`RTC_OFS_MINUTES: r[5:0] = s.min_cnt;
			`RTC_OFS_HOURS:   r[4:0] = s.hour_cnt;
			default:          r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	rtc_tick u_tick (
		.sys_clk           (sys_clk),
		.rst_n             (rst_n),
		.src_sel           (s_reg.src_sel),
		.main_osc_clock    (main_osc_clock),
		.sub_osc_clock     (sub_osc_clock),
		.internal_rc_clock (internal_rc_clock),
		.step              (step)
	);

	always_comb begin
		s_next      = s_reg;
		reload_next = reload_reg;
		ev          = 5'h00;
		wd          = s_reg.wdata;
		ws          = s_reg.wstrb;
		mw          = 32'h0000_0000;
		reload_hit  = step && s_reg.start && s_reg.run && s_reg.down_cnt == `RTC_DOWN_ZERO;

		// bus: address and data are taken in either order, answer after both
		if (axi_req.awvalid && s_reg.rsp.awready) begin
			s_next.aw_got  = 1'b1;
			s_next.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && s_reg.rsp.wready) begin
			s_next.w_got = 1'b1;
			s_next.wdata = axi_req.wdata;
			s_next.wstrb = axi_req.wstrb;
		end
		if (axi_req.bready && s_reg.rsp.bvalid) begin
			s_next.rsp.bvalid = 1'b0;
		end
		wr_fire = s_reg.aw_got && s_reg.w_got && !s_reg.rsp.bvalid;

		// time base; nothing here looks at standby, so timer mode keeps counting
		if (!s_reg.start) begin
			s_next.down_cnt = `RTC_DOWN_ZERO;
			s_next.sec_cnt  = 6'h00;
			s_next.min_cnt  = 6'h00;
			s_next.hour_cnt = 5'h00;
			s_next.half     = 1'b0;
			// pin restarts low so it stays in step with the half-second phase
			s_next.pin_out  = 1'b0;
			s_next.run      = 1'b0;
			s_next.update   = 1'b0;
		end else if (!s_reg.run) begin
			s_next.sec_cnt  = s_reg.sec_val;
			s_next.min_cnt  = s_reg.min_val;
			s_next.hour_cnt = s_reg.hour_val;
			s_next.down_cnt = reload_reg;
			s_next.run      = 1'b1;
		end else if (reload_hit) begin
			s_next.down_cnt       = reload_reg;
			ev[`RTC_EV_HALF]      = 1'b1;
			s_next.half           = !s_reg.half;
			s_next.pin_out        = !s_reg.half;
			ev[`RTC_EV_SEC]       = s_reg.half;
			if (s_reg.update) begin
				s_next.sec_cnt  = s_reg.sec_val;
				s_next.min_cnt  = s_reg.min_val;
				s_next.hour_cnt = s_reg.hour_val;
				s_next.update   = 1'b0;
			end else if (s_reg.half) begin
				s_next.sec_cnt = s_reg.sec_cnt + 6'h01;
				if (s_reg.sec_cnt == `RTC_SEC_LAST) begin
					s_next.sec_cnt  = 6'h00;
					ev[`RTC_EV_MIN] = 1'b1;
					s_next.min_cnt  = s_reg.min_cnt + 6'h01;
					if (s_reg.min_cnt == `RTC_MIN_LAST) begin
						s_next.min_cnt   = 6'h00;
						ev[`RTC_EV_HOUR] = 1'b1;
						s_next.hour_cnt  = s_reg.hour_cnt + 5'h01;
						if (s_reg.hour_cnt == `RTC_HOUR_LAST) begin
							s_next.hour_cnt = 5'h00;
							ev[`RTC_EV_DAY] = 1'b1;
						end
					end
				end
			end
		end else if (step) begin
			s_next.down_cnt = s_reg.down_cnt - 21'h000001;
		end

		// events are single-cycle pulses in this domain, so each sets its flag once
		s_next.flags = s_reg.flags | ev;

		if (wr_fire) begin
			s_next.aw_got     = 1'b0;
			s_next.w_got      = 1'b0;
			s_next.rsp.bvalid = 1'b1;
			s_next.rsp.bresp  = mapped(s_reg.aw_addr) ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
			// bits 7..4 of control are never stored, so stray writes cannot disturb them
			unique case (s_reg.aw_addr)
				`RTC_OFS_CONTROL: begin
					if (ws[1]) begin
						s_next.en[`RTC_EV_DAY]  = wd[`RTC_BIT_DAY_EN];
						s_next.en[`RTC_EV_HOUR] = wd[`RTC_BIT_HOUR_EN];
						s_next.en[`RTC_EV_MIN]  = wd[`RTC_BIT_MIN_EN];
						s_next.en[`RTC_EV_SEC]  = wd[`RTC_BIT_SEC_EN];
						// a clear loses to an event in the same cycle
						s_next.flags[`RTC_EV_DAY]  = s_next.flags[`RTC_EV_DAY] &
							(wd[`RTC_BIT_DAY_FLAG] | ev[`RTC_EV_DAY]);
						s_next.flags[`RTC_EV_HOUR] = s_next.flags[`RTC_EV_HOUR] &
							(wd[`RTC_BIT_HOUR_FLAG] | ev[`RTC_EV_HOUR]);
						s_next.flags[`RTC_EV_MIN]  = s_next.flags[`RTC_EV_MIN] &
							(wd[`RTC_BIT_MIN_FLAG] | ev[`RTC_EV_MIN]);
						s_next.flags[`RTC_EV_SEC]  = s_next.flags[`RTC_EV_SEC] &
							(wd[`RTC_BIT_SEC_FLAG] | ev[`RTC_EV_SEC]);
					end
					if (ws[0]) begin
						s_next.start = wd[`RTC_BIT_START];
						s_next.oe    = wd[`RTC_BIT_OE];
						if (wd[`RTC_BIT_UPDATE]) begin
							s_next.update = 1'b1;
						end
					end
				end
				`RTC_OFS_CONTROL_X: begin
					if (ws[0]) begin
						s_next.en[`RTC_EV_HALF]    = wd[`RTC_BIT_HALF_EN];
						s_next.flags[`RTC_EV_HALF] = s_next.flags[`RTC_EV_HALF] &
							(wd[`RTC_BIT_HALF_FLAG] | ev[`RTC_EV_HALF]);
					end
				end
				`RTC_OFS_SRC_SEL: begin
					if (ws[1]) begin
						s_next.src_sel = wd[`RTC_BIT_SRC_LO +: 2];
					end
				end
				`RTC_OFS_RELOAD: begin
					mw          = merge({11'h000, reload_reg}, wd, ws);
					reload_next = mw[20:0];
				end
				`RTC_OFS_SECONDS: begin
					mw             = merge({26'h0000000, s_reg.sec_val}, wd, ws);
					s_next.sec_val = mw[5:0];
				end
				`RTC_OFS_MINUTES: begin
					mw             = merge({26'h0000000, s_reg.min_val}, wd, ws);
					s_next.min_val = mw[5:0];
				end
				`RTC_OFS_HOURS: begin
					mw              = merge({27'h0000000, s_reg.hour_val}, wd, ws);
					s_next.hour_val = mw[4:0];
				end
				default:          s_next.rsp.bresp = `RTC_RESP_SLVERR;
			endcase
		end

		if (axi_req.rready && s_reg.rsp.rvalid) begin
			s_next.rsp.rvalid = 1'b0;
		end
		if (axi_req.arvalid && s_reg.rsp.arready) begin
			s_next.rsp.rvalid = 1'b1;
			s_next.rsp.rdata  = read_word(s_reg, reload_reg, axi_req.araddr);
			s_next.rsp.rresp  = mapped(axi_req.araddr) ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
		end

		// other reset causes clear control state; time values survive
		if (!soft_rst_n) begin
			s_next.flags   = 5'h00;
			s_next.en      = 5'h00;
			s_next.oe      = 1'b0;
			s_next.start   = 1'b0;
			s_next.update  = 1'b0;
			s_next.src_sel = `RTC_SRC_MAIN;
		end

		s_next.rsp.awready = !s_next.aw_got && !s_next.rsp.bvalid;
		s_next.rsp.wready  = !s_next.w_got && !s_next.rsp.bvalid;
		s_next.rsp.arready = !s_next.rsp.rvalid;
		s_next.pin_oe      = s_next.oe;
		s_next.irq         = |(s_next.flags & s_next.en);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// reload value has no reset: it rides through every reset cause
	always_ff @(posedge sys_clk) begin
		reload_reg <= reload_next;
	end

	assign axi_rsp             = s_reg.rsp;
	assign timer_output_pin    = s_reg.pin_out;
	assign timer_output_pin_oe = s_reg.pin_oe;
	assign irq                 = s_reg.irq;

	sequence seq_flag_clear_write(int b);
		wr_fire && s_reg.aw_addr == `RTC_OFS_CONTROL && ws[1] && !wd[b];
	endsequence

	chk_stop_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!s_reg.start |=> s_reg.down_cnt == `RTC_DOWN_ZERO && s_reg.sec_cnt == 6'h00 &&
			s_reg.min_cnt == 6'h00 && s_reg.hour_cnt == 5'h00 && !s_reg.run)
		else $error("counters not cleared while stopped");

	chk_start_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_reg.start && !s_reg.run && soft_rst_n |=> s_reg.run && s_reg.down_cnt == $past(reload_reg) &&
			s_reg.sec_cnt == $past(s_reg.sec_val) && s_reg.hour_cnt == $past(s_reg.hour_val))
		else $error("start did not load counters");

	chk_reload_half: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reload_hit && soft_rst_n |=> s_reg.down_cnt == $past(reload_reg) && s_reg.flags[`RTC_EV_HALF])
		else $error("expiry did not reload or flag half second");

	chk_second_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reload_hit && s_reg.half && !s_reg.update && s_reg.sec_cnt == `RTC_SEC_LAST && soft_rst_n
		|=> s_reg.sec_cnt == 6'h00 && s_reg.flags[`RTC_EV_MIN] && s_reg.flags[`RTC_EV_SEC])
		else $error("second wrap wrong");

	chk_day_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reload_hit && s_reg.half && !s_reg.update && s_reg.sec_cnt == `RTC_SEC_LAST &&
		s_reg.min_cnt == `RTC_MIN_LAST && s_reg.hour_cnt == `RTC_HOUR_LAST && soft_rst_n
		|=> s_reg.hour_cnt == 5'h00 && s_reg.flags[`RTC_EV_DAY])
		else $error("day wrap wrong");

	chk_update_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reload_hit && s_reg.update && !wr_fire && soft_rst_n
		|=> !s_reg.update && s_reg.min_cnt == $past(s_reg.min_val))
		else $error("update not applied at reload");

	chk_flag_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
		seq_flag_clear_write(`RTC_BIT_DAY_FLAG) and !ev[`RTC_EV_DAY] |=> !s_reg.flags[`RTC_EV_DAY])
		else $error("day flag not cleared by zero write");

	chk_irq_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(s_reg.flags[`RTC_EV_SEC]) && s_reg.en[`RTC_EV_SEC] |-> irq ##1 1'b1)
		else $error("enabled second flag gave no request");

	chk_pin_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reload_hit && s_reg.oe && !wr_fire && soft_rst_n
		|=> timer_output_pin_oe && timer_output_pin != $past(timer_output_pin))
		else $error("driven pin did not toggle on reload");

endmodule

// File: verification/rtc_top_tb.sv
/*
 file: self-checking testbench of the real time clock top, driving AXI4-Lite and the source clocks.
 assumes: rtc_pkg and rtc_consts.svh compiled first; assertions live in the design files.
*/
`timescale 1ns/1ps

module testbench
	import rtc_pkg::*;
;
	logic            sys_clk;
	logic            rst_n;
	logic            soft_rst_n;
	logic            src_main;
	logic            src_sub;
	logic            src_rc;
	rtc_axi_req_type req;
	rtc_axi_rsp_type rsp;
	logic            pin;
	logic            pin_oe;
	logic            irq;
	int              fails;
	int              checks;
	int              cyc;
	logic [31:0]     rd;
	logic [1:0]      resp;
	logic [5:0]      vs;
	logic [5:0]      vm;
	logic [4:0]      vh;
	logic [16:0]     nt;

	rtc_top u_dut (
		.sys_clk            (sys_clk),
		.rst_n              (rst_n),
		.soft_rst_n         (soft_rst_n),
		.axi_req            (req),
		.axi_rsp            (rsp),
		.main_osc_clock     (src_main),
		.sub_osc_clock      (src_sub),
		.internal_rc_clock  (src_rc),
		.timer_output_pin   (pin),
		.timer_output_pin_oe(pin_oe),
		.irq                (irq)
	);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// sources differ in period; select codes are checked by readback, and code 3 by time standing; all at most a quarter of sys_clk
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cyc      <= 0;
			src_main <= 1'b0;
			src_sub  <= 1'b0;
			src_rc   <= 1'b0;
		end else begin
			cyc      <= cyc + 1;
			src_main <= (cyc % 8) < 4;
			src_sub  <= (cyc % 10) < 5;
			src_rc   <= (cyc % 12) < 6;
		end
	end

	task automatic give_verdict;
		if (fails == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic timed_out(input string what);
		fails++;
		$display("unexpected %0t timeout %s", $time, what);
		give_verdict();
	endtask

	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %0t response got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic got, input logic exp, input string what);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	// bready and rready stay high throughout, so only the valids and payload move here
	task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
		int n;
		req.awaddr <= a;
		req.awvalid <= 1'b1;
		req.wdata <= d;
		req.wvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (req.awvalid && rsp.awready)
				req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready)
				req.wvalid <= 1'b0;
			if (rsp.bvalid) begin
				resp = rsp.bresp;
				return;
			end
		end
		timed_out("write");
	endtask

	task automatic bus_rd(input logic [4:0] a);
		int n;
		req.araddr <= a;
		req.arvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (req.arvalid && rsp.arready)
				req.arvalid <= 1'b0;
			if (rsp.rvalid) begin
				rd = rsp.rdata;
				resp = rsp.rresp;
				return;
			end
		end
		timed_out("read");
	endtask

	task automatic poll(input logic [4:0] a, input logic [31:0] mask, input logic [31:0] val);
		int n;
		for (n = 0; n < 300; n++) begin
			bus_rd(a);
			if ((rd & mask) === val)
				return;
		end
		timed_out("poll");
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string what);
		bus_rd(a);
		chk_data(rd, exp, what);
	endtask

	// time one second later, packed hours, minutes, seconds
	function automatic logic [16:0] time_advance(input logic [4:0] h, input logic [5:0] m, input logic [5:0] s);
		if (s != 6'h3B)
			return {h, m, s + 6'h01};
		if (m != 6'h3B)
			return {h, m + 6'h01, 6'h00};
		return {(h == 5'h17) ? 5'h00 : h + 5'h01, 6'h00, 6'h00};
	endfunction

	initial begin
		rst_n = 1'b0;
		soft_rst_n = 1'b1;
		req = '0;
		req.wstrb = 4'hF;
		req.bready = 1'b1;
		req.rready = 1'b1;
		fails = 0;
		checks = 0;
		rd = $urandom(62755);
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 7; i++)
			if (i != 3) rd_chk(5'(i * 4), 32'h0000_0000, "reset value");
		bus_wr(5'h1C, 32'hFFFF_FFFF);
		chk_resp(resp, 2'h2);
		bus_rd(5'h1C);
		chk_resp(resp, 2'h2);
		chk_data(rd, 32'h0000_0000, "unmapped read");
		bus_wr(5'h00, 32'h0000_00F0);
		rd_chk(5'h00, 32'h0000_0000, "reserved bits");
		// wrap of all three counters in one second, short reload keeps the run brief
		bus_wr(5'h0C, 32'h0000_0003);
		bus_wr(5'h10, 32'h0000_003B);
		bus_wr(5'h14, 32'h0000_003B);
		bus_wr(5'h18, 32'h0000_0017);
		bus_wr(5'h04, 32'h0000_0002);
		bus_wr(5'h00, 32'h0000_AA01);
		repeat (4) @(posedge sys_clk);
		rd_chk(5'h00, 32'h0000_AA09, "run after start");
		rd_chk(5'h10, 32'h0000_003B, "seconds loaded");
		poll(5'h00, 32'h0000_0100, 32'h0000_0100);
		nt = time_advance(5'h17, 6'h3B, 6'h3B);
		chk_data(rd, 32'h0000_FF09, "wrap flags");
		rd_chk(5'h10, {26'h0, nt[5:0]}, "seconds wrap");
		rd_chk(5'h14, {26'h0, nt[11:6]}, "minutes wrap");
		rd_chk(5'h18, {27'h0, nt[16:12]}, "hours wrap");
		rd_chk(5'h04, 32'h0000_0003, "half flag");
		chk_pin(irq, 1'b1, "irq enabled");
		// flags are all set here, so a one that cleared them would show
		bus_wr(5'h00, 32'h0000_FF01);
		rd_chk(5'h00, 32'h0000_FF09, "write one keeps flag");
		bus_wr(5'h04, 32'h0000_0000);
		bus_wr(5'h00, 32'h0000_AA01);
		@(posedge sys_clk);
		chk_pin(irq, 1'b0, "irq cleared");
		rd_chk(5'h00, 32'h0000_AA09, "zero clears flags");
		// update while running lands at the next reload
		vs = 6'($urandom % 58);
		bus_wr(5'h10, {26'h0, vs});
		bus_wr(5'h00, 32'h0000_0005);
		bus_rd(5'h00);
		chk_data(rd & 32'h4, 32'h0000_0004, "update pending");
		poll(5'h00, 32'h0000_0004, 32'h0000_0000);
		rd_chk(5'h10, {26'h0, vs}, "update seconds");
		bus_wr(5'h00, 32'h0000_0003);
		@(posedge sys_clk);
		chk_pin(pin_oe, 1'b1, "pin enable");
		rd[0] = pin;
		for (int n = 0; n < 100 && pin === rd[0]; n++)
			@(posedge sys_clk);
		chk_pin(pin, ~rd[0], "pin toggles");
		// random restart values reach the counters
		for (int k = 0; k < 3; k++) begin
			bus_wr(5'h00, 32'h0000_0000);
			repeat (4) @(posedge sys_clk);
			rd_chk(5'h10, 32'h0000_0000, "stop clears");
			chk_pin(pin, 1'b0, "pin low when stopped");
			vs = 6'($urandom % 60);
			vm = 6'($urandom % 60);
			vh = 5'($urandom % 24);
			bus_wr(5'h10, {26'h0, vs});
			bus_wr(5'h14, {26'h0, vm});
			bus_wr(5'h18, {27'h0, vh});
			bus_wr(5'h00, 32'h0000_0001);
			repeat (4) @(posedge sys_clk);
			rd_chk(5'h10, {26'h0, vs}, "start seconds");
			rd_chk(5'h14, {26'h0, vm}, "start minutes");
			rd_chk(5'h18, {27'h0, vh}, "start hours");
		end
		bus_wr(5'h08, 32'h0000_0100);
		soft_rst_n <= 1'b0;
		@(posedge sys_clk);
		soft_rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd_chk(5'h00, 32'h0000_0000, "soft reset control");
		rd_chk(5'h08, 32'h0000_0000, "soft reset select");
		bus_wr(5'h00, 32'h0000_0001);
		repeat (4) @(posedge sys_clk);
		rd_chk(5'h18, {27'h0, vh}, "hours kept");
		for (int c = 0; c < 4; c++) begin
			bus_wr(5'h08, 32'(c) << 8);
			rd_chk(5'h08, 32'(c) << 8, "source select");
		end
		bus_rd(5'h10);
		nt[5:0] = rd[5:0];
		repeat (400) @(posedge sys_clk);
		rd_chk(5'h10, {26'h0, nt[5:0]}, "no source stands");
		give_verdict();
	end

	initial begin
		#9_000_000;
		timed_out("run");
	end
endmodule
